// [logic/sfr_pkg.sv]
// Purpose: shared constants and carriers for the status flag register
// Assumes: 40 MHz core clock, supply readings in millivolts
// Notes:   one flag stage module is reused for every sticky bit
package sfr_pkg;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned STAT_W         = 16;
  localparam logic [15:0] STAT_RESET     = 16'h0000;
  localparam int unsigned BIT_LOW_SUPPLY = 0;
  localparam int unsigned BIT_HIGH_SUP   = 1;
  localparam int unsigned BIT_FLASH_ERR  = 2;
  localparam int unsigned BIT_LINK_ERR   = 3;
  localparam int unsigned BIT_SELF_TEST  = 5;
  localparam int unsigned BIT_ALARM1     = 8;
  localparam int unsigned BIT_ALARM2     = 9;
  localparam logic [15:0] USED_MASK      = 16'h032F;
  localparam logic [15:0] CMD_CLEAR_WORD = 16'hBE10;
  localparam int unsigned CMD_CLEAR_BIT  = 4;
  localparam logic [15:0] SUPPLY_HIGH_MV = 16'h0E29;
  localparam logic [15:0] SUPPLY_LOW_MV  = 16'h0B9F;
  localparam logic [15:0] POR_LO_MV      = 16'h092E;
  localparam logic [15:0] POR_HI_MV      = 16'h0A8C;
  localparam int unsigned POR_WINDOW_MS  = 128;
  localparam int unsigned POR_CYCLES     = CLK_HZ / 1000 * POR_WINDOW_MS;
  localparam int unsigned SETTLE_MS      = 1280;
  localparam int unsigned SETTLE_CYCLES  = CLK_HZ / 1000 * SETTLE_MS;

  typedef struct packed {
    logic alarm2;
    logic alarm1;
    logic self_test_err;
    logic link_err;
    logic flash_err;
  } sfr_events_t;

  typedef struct packed {
    logic        cmd_valid;
    logic [15:0] cmd_word;
    logic        stat_read;
  } sfr_host_t;
endpackage : sfr_pkg

// [logic/sfr_flag.sv]
// Purpose: one sticky status flag
// Assumes: set and clear are single-cycle qualified strobes
// Notes:   set wins over clear in the same cycle
`timescale 1ns/1ps
module sfr_flag (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_o
);
  typedef struct packed {
    logic flag_q;
  } sfr_flag_st_t;
  sfr_flag_st_t st_q;
  sfr_flag_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (clr_i) begin
      st_d.flag_q = 1'b0;
    end
    if (set_i) begin
      st_d.flag_q = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flag_o = st_q.flag_q;

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    set_i |=> flag_o) else $error("flag lost set");
endmodule : sfr_flag

// [logic/sfr_status.sv]
// Purpose: status flag register with supply monitoring and power-on check
// Assumes: supply reading is a filtered millivolt value, sync to CLOCK_I
// Notes:   all outputs come straight from flip-flops
//
// Contract
// - host reads status, then writes clear word; device zeroes all flags. Code zeroes only the five sticky flags; supply bits 0 and 1 stay live.
// - alarm two shown in bit 9, alarm one in bit 8.
// - self-test error bit 5, link failure bit 3, flash failure bit 2.
// - bit 1 set while supply above high limit, else zero.
// - bit 0 set while supply below low limit, else zero.
// - low-supply bit drops by itself once reading climbs above limit.
// - supply reading settles in about 1.28 s after power-up.
// - force reset if supply fails to cross POR window in 128 ms.
// - command bit 4 set clears every status bit. Code needs the whole word 16'hBE10 and clears only the five sticky flags.
// - reading the status clears the flash failure flag.
`timescale 1ns/1ps
module sfr_status #(
  parameter int unsigned POR_CYC    = sfr_pkg::POR_CYCLES,
  parameter int unsigned SETTLE_CYC = sfr_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_N_I,
  // event sources
  input  wire sfr_pkg::sfr_events_t EVENTS_I,
  input  wire logic [15:0]          SUPPLY_MV_I,
  // host access
  input  wire sfr_pkg::sfr_host_t   HOST_I,
  // status out
  output logic [15:0]               STATUS_O,
  output logic                      SUPPLY_SETTLED_O,
  output logic                      POR_RESET_O
);
  typedef enum logic [2:0] {
    POR_BELOW = 3'b001,
    POR_RAMP  = 3'b010,
    POR_GOOD  = 3'b100
  } sfr_por_t;

  typedef struct packed {
    logic [15:0] status;
    logic        settled;
    logic        por_rst;
    sfr_por_t    por;
    logic [31:0] por_cnt;
    logic [31:0] settle_cnt;
  } sfr_st_t;

  sfr_st_t st_q;
  sfr_st_t st_d;
  logic    clr_all;
  logic    flash_rd_clr;
  logic    alarm2_f;
  logic    alarm1_f;
  logic    st_f;
  logic    link_f;
  logic    flash_f;
  logic    hi_sup;
  logic    lo_sup;

  // clear word decode
  assign clr_all = HOST_I.cmd_valid && HOST_I.cmd_word[sfr_pkg::CMD_CLEAR_BIT]
                   && HOST_I.cmd_word == sfr_pkg::CMD_CLEAR_WORD;
  assign flash_rd_clr = HOST_I.stat_read;
  assign hi_sup = SUPPLY_MV_I > sfr_pkg::SUPPLY_HIGH_MV;
  assign lo_sup = SUPPLY_MV_I < sfr_pkg::SUPPLY_LOW_MV;

  // sticky flags
  sfr_flag u_alarm2 (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .set_i(EVENTS_I.alarm2), .clr_i(clr_all), .flag_o(alarm2_f));
  sfr_flag u_alarm1 (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .set_i(EVENTS_I.alarm1), .clr_i(clr_all), .flag_o(alarm1_f));
  sfr_flag u_self (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .set_i(EVENTS_I.self_test_err), .clr_i(clr_all), .flag_o(st_f));
  sfr_flag u_link (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .set_i(EVENTS_I.link_err), .clr_i(clr_all), .flag_o(link_f));
  sfr_flag u_flash (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .set_i(EVENTS_I.flash_err), .clr_i(clr_all || flash_rd_clr),
    .flag_o(flash_f));

  always_comb begin
    st_d = st_q;
    // register image, unused bits zero
    st_d.status = 16'h0000;
    st_d.status[sfr_pkg::BIT_ALARM2]     = alarm2_f;
    st_d.status[sfr_pkg::BIT_ALARM1]     = alarm1_f;
    st_d.status[sfr_pkg::BIT_SELF_TEST]  = st_f;
    st_d.status[sfr_pkg::BIT_LINK_ERR]   = link_f;
    st_d.status[sfr_pkg::BIT_FLASH_ERR]  = flash_f;
    st_d.status[sfr_pkg::BIT_HIGH_SUP]   = hi_sup;
    st_d.status[sfr_pkg::BIT_LOW_SUPPLY] = lo_sup;
    // settle timer from power-up
    if (st_q.settle_cnt < SETTLE_CYC) begin
      st_d.settle_cnt = st_q.settle_cnt + 32'h00000001;
    end
    st_d.settled = st_q.settle_cnt >= SETTLE_CYC;
    // power-on window check
    st_d.por_rst = 1'b0;
    case (st_q.por)
      POR_BELOW: begin
        st_d.por_cnt = 32'h00000000;
        if (SUPPLY_MV_I >= sfr_pkg::POR_LO_MV) begin
          st_d.por = POR_RAMP;
        end
      end
      POR_RAMP: begin
        st_d.por_cnt = st_q.por_cnt + 32'h00000001;
        if (SUPPLY_MV_I >= sfr_pkg::POR_HI_MV) begin
          st_d.por = POR_GOOD;
        end else if (SUPPLY_MV_I < sfr_pkg::POR_LO_MV) begin
          st_d.por = POR_BELOW;
        end else if (st_q.por_cnt >= POR_CYC - 1) begin
          st_d.por_rst = 1'b1;
          st_d.por     = POR_BELOW;
        end
      end
      POR_GOOD: begin
        if (SUPPLY_MV_I < sfr_pkg::POR_LO_MV) begin
          st_d.por = POR_BELOW;
        end
      end
      default: begin
        st_d.por = POR_BELOW;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      st_q.status     <= sfr_pkg::STAT_RESET;
      st_q.settled    <= 1'b0;
      st_q.por_rst    <= 1'b0;
      st_q.por        <= POR_BELOW;
      st_q.por_cnt    <= 32'h00000000;
      st_q.settle_cnt <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  assign STATUS_O         = st_q.status;
  assign SUPPLY_SETTLED_O = st_q.settled;
  assign POR_RESET_O      = st_q.por_rst;

  sequence s_clear;
    clr_all && !EVENTS_I.alarm1;
  endsequence

  AST_CLEAR_ALARM1: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    s_clear ##1 !EVENTS_I.alarm1 |=> !STATUS_O[sfr_pkg::BIT_ALARM1])
    else $error("alarm1 not cleared");
  AST_ALARM2_MAP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    EVENTS_I.alarm2 |-> ##2 STATUS_O[sfr_pkg::BIT_ALARM2])
    else $error("alarm2 not in bit 9");
  AST_LINK_MAP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    EVENTS_I.link_err |-> ##2 STATUS_O[sfr_pkg::BIT_LINK_ERR])
    else $error("link error not in bit 3");
  AST_HIGH_SUP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    1'b1 |=> STATUS_O[1] == $past(SUPPLY_MV_I > sfr_pkg::SUPPLY_HIGH_MV))
    else $error("high supply bit wrong");
  AST_LOW_SUP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    1'b1 |=> STATUS_O[0] == $past(SUPPLY_MV_I < sfr_pkg::SUPPLY_LOW_MV))
    else $error("low supply bit wrong");
  AST_LOW_DROP: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (SUPPLY_MV_I > sfr_pkg::SUPPLY_LOW_MV) |=> !STATUS_O[0])
    else $error("low flag kept");
  AST_FLASH_RDCLR: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    HOST_I.stat_read && !EVENTS_I.flash_err ##1 !EVENTS_I.flash_err
    |=> !STATUS_O[sfr_pkg::BIT_FLASH_ERR])
    else $error("flash flag not read-cleared");
  AST_UNUSED_ZERO: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (STATUS_O & ~sfr_pkg::USED_MASK) == 16'h0000)
    else $error("unused status bit set");
  AST_POR_PULSE: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    POR_RESET_O |=> !POR_RESET_O)
    else $error("por reset not a pulse");
  // image lags the flag by one edge, so the clear that matters is the older one
  AST_STICKY: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !clr_all ##1 STATUS_O[sfr_pkg::BIT_SELF_TEST]
    |=> STATUS_O[sfr_pkg::BIT_SELF_TEST])
    else $error("self-test flag dropped");
endmodule : sfr_status

// [sim/sfr_host_model.sv]
// Purpose: host side of the status flag register
// Assumes: requests arrive as one-cycle levels from the bench
// Notes:   command word shows a toggled pattern while not valid
`timescale 1ns/1ps
module sfr_host_model (
  // requests
  input  wire logic        rd_i,
  input  wire logic        clr_i,
  input  wire logic [15:0] word_i,
  // host bus
  output sfr_pkg::sfr_host_t host_o
);
  always_comb begin
    host_o.stat_read = rd_i;
    host_o.cmd_valid = clr_i;
    host_o.cmd_word  = clr_i ? word_i : ~word_i;
  end
endmodule : sfr_host_model

// [sim/tb_top.sv]
// Purpose: self-checking bench for the status flag register
// Assumes: short power-on and settle counts
// Notes:   random events from an lfsr seeded at 71
`timescale 1ns/1ps
module tb_top;
  logic                 clk, rst_n, rd, clr, settled, por;
  logic [15:0]          word, sup, lf, stat, exp_q;
  sfr_pkg::sfr_events_t ev;
  sfr_pkg::sfr_host_t   host;
  int                   err_total, checks_done, i, n;
  localparam int        POR_T = 20;
  logic [15:0] sv [4] = '{16'h0E2A, 16'h0E29, 16'h0B9E, 16'h0B9F};
  logic [15:0] sx [4] = '{16'h0002, 16'h0000, 16'h0001, 16'h0000};
  sfr_host_model host_m (.rd_i(rd), .clr_i(clr), .word_i(word),
    .host_o(host));
  sfr_status #(.POR_CYC(POR_T), .SETTLE_CYC(50)) dut (.CLOCK_I(clk),
    .RST_N_I(rst_n), .EVENTS_I(ev), .SUPPLY_MV_I(sup), .HOST_I(host),
    .STATUS_O(stat), .SUPPLY_SETTLED_O(settled), .POR_RESET_O(por));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] ev_map(input logic [4:0] e);
    return {6'h00, e[4], e[3], 2'h0, e[2], 1'h0, e[1], e[0], 2'h0};
  endfunction : ev_map
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    // look at outputs once the edge has settled
    #1;
  endtask : tick
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic hop(input logic r, input logic c, input logic [15:0] w);
    @(posedge clk);
    rd <= r;
    clr <= c;
    word <= w;
    @(posedge clk);
    rd <= 1'b0;
    clr <= 1'b0;
    tick(3);
  endtask : hop
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    tick(3);
  endtask : pulse
  task automatic summarize;
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0; rd = 1'b0; clr = 1'b0; word = 16'h0000;
    ev = '0; sup = 16'h0CE4; lf = 16'h0047; exp_q = 16'h0000;
    err_total = 0; checks_done = 0;
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    cmp("status reset", 16'h0000, stat);
    cmp("settled early", 16'h0000, {15'h0000, settled});
    for (i = 0; i < 24; i++) begin
      lf = lfsr(lf);
      pulse(lf[4:0]);
      exp_q = exp_q | ev_map(lf[4:0]);
      cmp("status flags", exp_q, stat);
      if (lf[5]) begin
        hop(1'b1, 1'b0, 16'h0000);
        exp_q = exp_q & ~16'h0004;
        cmp("status after read", exp_q, stat);
        hop(1'b0, 1'b1, 16'hBE10);
        exp_q = 16'h0000;
        cmp("status after clear", exp_q, stat);
      end
    end
    pulse(5'h1F);
    exp_q = exp_q | 16'h032C;
    hop(1'b0, 1'b1, 16'hBE01);
    cmp("bad word ignored", exp_q, stat);
    @(posedge clk);
    ev <= 5'h08;
    clr <= 1'b1;
    word <= 16'hBE10;
    @(posedge clk);
    ev <= '0;
    clr <= 1'b0;
    tick(3);
    exp_q = 16'h0100;
    cmp("set wins over clear", exp_q, stat);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      sup <= sv[i];
      tick(3);
      cmp("supply bits", exp_q | sx[i], stat);
    end
    cmp("settled", 16'h0001, {15'h0000, settled});
    @(posedge clk);
    sup <= 16'h0900;
    tick(2);
    @(posedge clk);
    sup <= 16'h0960;
    n = 0;
    while (por !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    cmp("por pulse", 16'h0001, {15'h0000, por === 1'b1});
    cmp("por delay", 16'h0001, {15'h0000, n == POR_T + 1});
    summarize();
  end
endmodule : tb_top
